/* File: ufts_chk.sv */
// Bus and line checker of the serial status-flag block
`timescale 1ns/1ns
`default_nettype none
module ufts_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // Line and power
  input wire logic        txd,
  input wire logic        standby,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_lat; arvalid && arready |=> rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer off");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold; bvalid && !bready |=> bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_ar_block; rvalid |-> !arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_aw_block; bvalid |-> !awready && !wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  property p_sby_txd; standby |=> txd[*2]; endproperty
  a_sby_txd: assert property (p_sby_txd) else $error("line not idle in standby");
  property p_rst_txd; $rose(aresetn) |-> txd && !irq; endproperty
  a_rst_txd: assert property (p_rst_txd) else $error("line or irq wrong after reset");
  c_irq: cover property (irq);
  c_sby: cover property (standby);
  c_rd: cover property (rvalid && rready);
endmodule : ufts_chk
bind ufts_top ufts_chk i_ufts_chk (.*);
`default_nettype wire

/* File: ufts_pkg.sv */
// Shared constants and types of the serial status-flag block
package ufts_pkg;

  // AXI4-Lite geometry
  localparam int          UFTS_ADDR_W     = 8;
  localparam int          UFTS_DATA_W     = 32;
  localparam logic [1:0]  UFTS_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  UFTS_RESP_SLVERR = 2'h2;

  // Register byte offsets
  localparam logic [7:0]  UFTS_OFF_CTRL     = 8'h00;  // serial_control_reg
  localparam logic [7:0]  UFTS_OFF_FCTRL    = 8'h04;  // fifo_control_reg
  localparam logic [7:0]  UFTS_OFF_STATUS   = 8'h08;  // serial_status_reg
  localparam logic [7:0]  UFTS_OFF_TXFIFO   = 8'h0C;  // tx_fifo
  localparam logic [7:0]  UFTS_OFF_BAUD     = 8'h10;
  localparam logic [7:0]  UFTS_OFF_IRQ_ST   = 8'h14;
  localparam logic [7:0]  UFTS_OFF_IRQ_MASK = 8'h18;

  // Field positions
  localparam int UFTS_CTRL_TE_BIT   = 0;
  localparam int UFTS_FCR_TTRG_LO   = 4;
  localparam int UFTS_FCR_TTRG_HI   = 5;
  localparam int UFTS_ST_TX_END_FLAG_BIT   = 6;
  localparam int UFTS_ST_TX_FIFO_LOW_FLAG_BIT   = 5;
  localparam int UFTS_ST_BRK_BIT    = 4;
  localparam int UFTS_CNT_LSB       = 8;
  localparam int UFTS_CNT_FIELD_W   = 8;

  // Flag indexes inside the read-tracking vector
  localparam int UFTS_FLG_BRK  = 0;
  localparam int UFTS_FLG_TX_FIFO_LOW_FLAG = 1;
  localparam int UFTS_FLG_TX_END_FLAG = 2;
  localparam int UFTS_NFLG     = 3;

  // Transmit FIFO
  localparam int         UFTS_FIFO_DEPTH = 16;
  localparam int         UFTS_PTR_W      = 4;
  localparam int         UFTS_CNT_W      = 5;
  localparam logic [4:0] UFTS_FIFO_FULL  = 5'h10;
  localparam logic [4:0] UFTS_TTRG_CNT0  = 5'h08;
  localparam logic [4:0] UFTS_TTRG_CNT1  = 5'h04;
  localparam logic [4:0] UFTS_TTRG_CNT2  = 5'h02;
  localparam logic [4:0] UFTS_TTRG_CNT3  = 5'h01;

  // Bit timing: 16 oversampling ticks per bit, 8 data bits
  localparam logic [3:0]  UFTS_OVS_LAST  = 4'hF;
  localparam logic [3:0]  UFTS_OVS_MID   = 4'h7;
  localparam logic [2:0]  UFTS_LAST_DBIT = 3'h7;
  localparam logic [15:0] UFTS_BAUD_RST  = 16'h0035;

  typedef enum logic [1:0] {UFTS_TX_IDLE, UFTS_TX_START, UFTS_TX_DATA, UFTS_TX_STOP} ufts_tx_state_t;
  typedef enum logic [2:0] {UFTS_RX_IDLE, UFTS_RX_START, UFTS_RX_DATA, UFTS_RX_STOP, UFTS_RX_MARK} ufts_rx_state_t;

endpackage : ufts_pkg

/* File: ufts_remote.sv */
// Remote serial device: decodes the transmit line, sends a break on request
`timescale 1ns/1ns
`default_nettype none
module ufts_remote #(
  parameter int BIT_NS = 160
) (
  // Request
  input  wire logic  send,
  // Lines
  input  wire logic  txd,
  output logic       rxd,
  output logic [7:0] rx_byte
);
  // Space through start, data and stop times makes a framing error
  initial begin
    rxd = 1'b1;
    forever begin
      @(posedge send);
      rxd = 1'b0;
      #(BIT_NS * 10);
      rxd = 1'b1;
    end
  end
  // Mid-bit sampling, least significant bit first
  always @(negedge txd) begin
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      rx_byte[i] = txd;
      #BIT_NS;
    end
  end
endmodule : ufts_remote
`default_nettype wire

/* File: ufts_rx_frame.sv */
// Receive framer: reports each frame end with its framing error and space state
`timescale 1ns/1ns
`default_nettype none
module ufts_rx_frame (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Timing and control
  input  wire logic tick,
  input  wire logic clr,
  // Line
  input  wire logic rxd_pin,
  // Frame report
  output logic      frame_done,
  output logic      frame_ferr,
  output logic      frame_space
);
  import ufts_pkg::*;

  ufts_rx_state_t state_q;
  logic           s1_q, s2_q, s3_q, rxd_q;
  logic [3:0]     ovs_q;
  logic [2:0]     bit_q;
  logic [7:0]     data_q;
  logic           done_q, ferr_q, space_q;

  assign frame_done  = done_q;
  assign frame_ferr  = ferr_q;
  assign frame_space = space_q;

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      s3_q  <= 1'b1;
      rxd_q <= 1'b1;
    end else begin
      s1_q <= rxd_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        rxd_q <= s3_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    done_q <= 1'b0;
    if (!aresetn || clr) begin
      state_q <= UFTS_RX_IDLE;
      ovs_q   <= 4'h0;
      bit_q   <= 3'h0;
      data_q  <= 8'h00;
      ferr_q  <= 1'b0;
      space_q <= 1'b0;
    end else if (state_q == UFTS_RX_IDLE) begin
      ovs_q <= 4'h0;
      if (!rxd_q) begin
        state_q <= UFTS_RX_START;
      end
    end else if (state_q == UFTS_RX_MARK) begin
      // After a framing error wait for mark so a held space is one event
      if (rxd_q) begin
        state_q <= UFTS_RX_IDLE;
      end
    end else if (tick) begin
      ovs_q <= ovs_q + 4'h1;
      case (state_q)
        UFTS_RX_START: begin
          if (ovs_q == UFTS_OVS_MID) begin
            ovs_q   <= 4'h0;
            bit_q   <= 3'h0;
            state_q <= rxd_q ? UFTS_RX_IDLE : UFTS_RX_DATA;
          end
        end
        UFTS_RX_DATA: begin
          if (ovs_q == UFTS_OVS_LAST) begin
            data_q <= {rxd_q, data_q[7:1]};
            bit_q  <= bit_q + 3'h1;
            if (bit_q == UFTS_LAST_DBIT) begin
              state_q <= UFTS_RX_STOP;
            end
          end
        end
        UFTS_RX_STOP: begin
          if (ovs_q == UFTS_OVS_LAST) begin
            done_q  <= 1'b1;
            ferr_q  <= !rxd_q;
            space_q <= !rxd_q && (data_q == 8'h00);
            state_q <= rxd_q ? UFTS_RX_IDLE : UFTS_RX_MARK;
          end
        end
        default: state_q <= UFTS_RX_IDLE;
      endcase
    end
  end

endmodule : ufts_rx_frame
`default_nettype wire

/* File: ufts_top.sv */
// Serial port status flags: transmit end, transmit FIFO low, break, with AXI4-Lite access
`timescale 1ns/1ns
`default_nettype none
module ufts_top (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [ufts_pkg::UFTS_ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input  wire logic                          wvalid,
  output logic                               wready,
  input  wire logic [ufts_pkg::UFTS_DATA_W-1:0] wdata,
  input  wire logic [3:0]                    wstrb,
  // AXI4-Lite write response
  output logic                               bvalid,
  input  wire logic                          bready,
  output logic [1:0]                         bresp,
  // AXI4-Lite read address
  input  wire logic                          arvalid,
  output logic                               arready,
  input  wire logic [ufts_pkg::UFTS_ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic                               rvalid,
  input  wire logic                          rready,
  output logic [ufts_pkg::UFTS_DATA_W-1:0]   rdata,
  output logic [1:0]                         rresp,
  // Serial line
  output logic                               txd,
  input  wire logic                          rxd,
  // Power state
  input  wire logic                          standby,
  // Interrupt
  output logic                               irq
);
  import ufts_pkg::*;

  function automatic logic is_mapped(input logic [UFTS_ADDR_W-1:0] a);
    is_mapped = (a == UFTS_OFF_CTRL) || (a == UFTS_OFF_FCTRL) || (a == UFTS_OFF_STATUS) ||
                (a == UFTS_OFF_TXFIFO) || (a == UFTS_OFF_BAUD) || (a == UFTS_OFF_IRQ_ST) ||
                (a == UFTS_OFF_IRQ_MASK);
  endfunction : is_mapped

  function automatic logic [UFTS_CNT_W-1:0] trig_count(input logic [1:0] code);
    case (code)
      2'h0:    trig_count = UFTS_TTRG_CNT0;
      2'h1:    trig_count = UFTS_TTRG_CNT1;
      2'h2:    trig_count = UFTS_TTRG_CNT2;
      default: trig_count = UFTS_TTRG_CNT3;
    endcase
  endfunction : trig_count

  // Bus slave state
  logic                   aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [UFTS_ADDR_W-1:0] awaddr_q;
  logic [UFTS_DATA_W-1:0] wdata_q, rdata_q;
  logic [3:0]             wstrb_q;
  logic [1:0]             bresp_q, rresp_q;
  logic                   wr_go, rd_go, wr_lo;

  // Registers
  logic                   tx_enable_bit_q;
  logic                   tx_trigger_level_hi_q, tx_trigger_level_lo_q;
  logic [15:0]            baud_q, baud_cnt_q;
  logic                   tx_end_flag_q, tx_fifo_low_flag_q, break_flag_q;
  logic [UFTS_NFLG-1:0]   rd_seen_q;
  logic [7:0]             irq_st_q, irq_mask_q;
  logic                   prev_ferr_q;

  // FIFO storage
  logic [7:0]             tx_fifo_mem [UFTS_FIFO_DEPTH];
  logic [UFTS_PTR_W-1:0]  wr_ptr_q, rd_ptr_q;
  logic [UFTS_CNT_W-1:0]  cnt_q, trig, cnt_after_pop;

  // Events
  logic                   tick, push, pop, tx_busy, tx_done;
  logic                   rx_done, rx_ferr, rx_space;
  logic                   st_wr, st_rd;
  logic                   tx_end_flag_set, tx_fifo_low_flag_set, brk_set;
  logic [UFTS_NFLG-1:0]   sw_clr, flags;
  logic [7:0]             ev_vec;

  // ---------------- AXI4-Lite slave ----------------
  assign awready = !aw_hold_q && !bvalid_q;
  assign wready  = !w_hold_q && !bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Write takes effect one cycle after both halves are held
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_lo = wr_go && wstrb_q[0];
  assign rd_go = arvalid && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= UFTS_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(awaddr_q) ? UFTS_RESP_OKAY : UFTS_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read mux; status shows only the three flags, other bits read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= UFTS_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(araddr) ? UFTS_RESP_OKAY : UFTS_RESP_SLVERR;
      rdata_q  <= '0;
      case (araddr)
        UFTS_OFF_CTRL:     rdata_q[UFTS_CTRL_TE_BIT] <= tx_enable_bit_q;
        UFTS_OFF_FCTRL: begin
          rdata_q[UFTS_FCR_TTRG_HI] <= tx_trigger_level_hi_q;
          rdata_q[UFTS_FCR_TTRG_LO] <= tx_trigger_level_lo_q;
        end
        UFTS_OFF_STATUS: begin
          rdata_q[UFTS_ST_TX_END_FLAG_BIT] <= tx_end_flag_q;
          rdata_q[UFTS_ST_TX_FIFO_LOW_FLAG_BIT] <= tx_fifo_low_flag_q;
          rdata_q[UFTS_ST_BRK_BIT]  <= break_flag_q;
        end
        UFTS_OFF_TXFIFO:   rdata_q[UFTS_CNT_LSB +: UFTS_CNT_FIELD_W] <= {3'h0, cnt_q};
        UFTS_OFF_BAUD:     rdata_q[15:0] <= baud_q;
        UFTS_OFF_IRQ_ST:   rdata_q[7:0] <= irq_st_q;
        UFTS_OFF_IRQ_MASK: rdata_q[7:0] <= irq_mask_q;
        default:           rdata_q <= '0;
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- Control registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      tx_enable_bit_q <= 1'b0;
    end else if (wr_lo && awaddr_q == UFTS_OFF_CTRL) begin
      tx_enable_bit_q <= wdata_q[UFTS_CTRL_TE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_trigger_level_hi_q <= 1'b0;
      tx_trigger_level_lo_q <= 1'b0;
    end else if (wr_lo && awaddr_q == UFTS_OFF_FCTRL) begin
      tx_trigger_level_hi_q <= wdata_q[UFTS_FCR_TTRG_HI];
      tx_trigger_level_lo_q <= wdata_q[UFTS_FCR_TTRG_LO];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_q <= UFTS_BAUD_RST;
    end else if (wr_go && awaddr_q == UFTS_OFF_BAUD) begin
      if (wstrb_q[0]) baud_q[7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) baud_q[15:8] <= wdata_q[15:8];
    end
  end

  // Oversampling tick: one pulse every baud_q + 1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || baud_cnt_q >= baud_q) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end
  assign tick = aresetn && (baud_cnt_q >= baud_q);

  // ---------------- Transmit FIFO ----------------
  assign trig          = trig_count({tx_trigger_level_hi_q, tx_trigger_level_lo_q});
  assign push          = wr_lo && awaddr_q == UFTS_OFF_TXFIFO && cnt_q != UFTS_FIFO_FULL && !standby;
  assign pop           = tx_enable_bit_q && !tx_busy && cnt_q != '0 && !standby;
  assign cnt_after_pop = cnt_q - 5'h01;

  // Full FIFO leaves memory and pointers untouched on a write
  always_ff @(posedge aclk) begin
    if (push) begin
      tx_fifo_mem[wr_ptr_q] <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 4'h1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 4'h1;
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 5'h01;
        2'b01:   cnt_q <= cnt_after_pop;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  ufts_tx_shift u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .clr     (standby),
    .start   (pop),
    .data    (tx_fifo_mem[rd_ptr_q]),
    .busy    (tx_busy),
    .done    (tx_done),
    .txd     (txd)
  );

  ufts_rx_frame u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .tick        (tick),
    .clr         (standby),
    .rxd_pin     (rxd),
    .frame_done  (rx_done),
    .frame_ferr  (rx_ferr),
    .frame_space (rx_space)
  );

  // ---------------- Status flags ----------------
  assign st_wr    = wr_lo && awaddr_q == UFTS_OFF_STATUS;
  assign st_rd    = rd_go && araddr == UFTS_OFF_STATUS;
  assign flags    = {tx_end_flag_q, tx_fifo_low_flag_q, break_flag_q};

  // A zero written over a flag seen set clears it, FIFO low only while cnt_q exceeds trig; ones are ignored
  assign sw_clr[UFTS_FLG_TX_END_FLAG] = st_wr && !wdata_q[UFTS_ST_TX_END_FLAG_BIT] && rd_seen_q[UFTS_FLG_TX_END_FLAG];
  assign sw_clr[UFTS_FLG_TX_FIFO_LOW_FLAG] = st_wr && !wdata_q[UFTS_ST_TX_FIFO_LOW_FLAG_BIT] && rd_seen_q[UFTS_FLG_TX_FIFO_LOW_FLAG]
                                 && (cnt_q > trig);
  assign sw_clr[UFTS_FLG_BRK]  = st_wr && !wdata_q[UFTS_ST_BRK_BIT] && rd_seen_q[UFTS_FLG_BRK];

  assign tx_end_flag_set = tx_done && cnt_q == '0 && !push;
  assign tx_fifo_low_flag_set = pop && (cnt_after_pop < trig);
  assign brk_set  = rx_done && rx_ferr;

  // A later frame that again ends at space sets it too; the latch-up is the same
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      prev_ferr_q <= 1'b0;
    end else if (rx_done) begin
      prev_ferr_q <= rx_ferr && rx_space;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      tx_end_flag_q <= 1'b1;
    end else if (push) begin
      tx_end_flag_q <= 1'b0;
    end else if (tx_end_flag_set) begin
      tx_end_flag_q <= 1'b1;
    end else if (sw_clr[UFTS_FLG_TX_END_FLAG]) begin
      tx_end_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      tx_fifo_low_flag_q <= 1'b1;
    end else if (tx_fifo_low_flag_set) begin
      tx_fifo_low_flag_q <= 1'b1;
    end else if (sw_clr[UFTS_FLG_TX_FIFO_LOW_FLAG]) begin
      tx_fifo_low_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      break_flag_q <= 1'b0;
    end else if (brk_set || (rx_done && rx_ferr && rx_space && prev_ferr_q)) begin
      break_flag_q <= 1'b1;
    end else if (sw_clr[UFTS_FLG_BRK]) begin
      break_flag_q <= 1'b0;
    end
  end

  // Read-while-set memory; a fresh set drops it so the next zero write cannot erase it
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      rd_seen_q <= '0;
    end else begin
      if (st_wr) rd_seen_q <= '0;
      if (st_rd) rd_seen_q <= flags;
      if (tx_end_flag_set) rd_seen_q[UFTS_FLG_TX_END_FLAG] <= 1'b0;
      if (tx_fifo_low_flag_set) rd_seen_q[UFTS_FLG_TX_FIFO_LOW_FLAG] <= 1'b0;
      if (brk_set)  rd_seen_q[UFTS_FLG_BRK]  <= 1'b0;
    end
  end

  // ---------------- Interrupts ----------------
  always_comb begin
    ev_vec                   = 8'h00;
    ev_vec[UFTS_ST_TX_END_FLAG_BIT] = tx_end_flag_set;
    ev_vec[UFTS_ST_TX_FIFO_LOW_FLAG_BIT] = tx_fifo_low_flag_set;
    ev_vec[UFTS_ST_BRK_BIT]  = brk_set;
  end

  // Set beats a write-one clear arriving in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= 8'h00;
    end else begin
      irq_st_q <= ev_vec | (irq_st_q & ~((wr_lo && awaddr_q == UFTS_OFF_IRQ_ST) ? wdata_q[7:0] : 8'h00));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= 8'h00;
    end else if (wr_lo && awaddr_q == UFTS_OFF_IRQ_MASK) begin
      irq_mask_q <= wdata_q[7:0] & (8'h00 | ev_mask());
    end
  end

  function automatic logic [7:0] ev_mask();
    ev_mask                   = 8'h00;
    ev_mask[UFTS_ST_TX_END_FLAG_BIT] = 1'b1;
    ev_mask[UFTS_ST_TX_FIFO_LOW_FLAG_BIT] = 1'b1;
    ev_mask[UFTS_ST_BRK_BIT]  = 1'b1;
  endfunction : ev_mask

  assign irq = |(irq_st_q & irq_mask_q);

endmodule : ufts_top
`default_nettype wire

/* File: ufts_top_tb.sv */
// Self-checking bench of the serial status-flag block
`timescale 1ns/1ns
`default_nettype none
module ufts_top_tb;
  import ufts_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} ufts_row_t;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, standby, send;
  logic        awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
  logic [7:0]  awaddr, araddr, rx_byte;
  logic [31:0] wdata, rdata, data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          num_errors = 0;
  int          samples_checked = 0;
  ufts_row_t   rows [5] = '{'{UFTS_OFF_STATUS, 32'h60, UFTS_RESP_OKAY}, '{UFTS_OFF_CTRL, 32'h0, UFTS_RESP_OKAY},
                            '{UFTS_OFF_TXFIFO, 32'h0, UFTS_RESP_OKAY}, '{UFTS_OFF_BAUD, 32'h35, UFTS_RESP_OKAY},
                            '{8'h1C, 32'h0, UFTS_RESP_SLVERR}};
  always #5 aclk = ~aclk;
  ufts_top i_ufts_top (.*);
  ufts_remote #(.BIT_NS(160)) i_ufts_remote (.send(send), .txd(txd), .rxd(rxd), .rx_byte(rx_byte));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      @(posedge aclk iff awready) awvalid <= 1'b0;
      @(posedge aclk iff wready) wvalid <= 1'b0;
      begin
        @(posedge aclk iff bvalid) bready <= 1'b0;
        resp = bresp;
      end
    join
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk iff arready) arvalid <= 1'b0;
    @(posedge aclk iff rvalid) rready <= 1'b0;
    data = rdata;
    resp = rresp;
  endtask : rd
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, standby, send} <= '0;
    {awaddr, araddr, wdata} <= '0;
    wstrb <= 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(data, rows[i].d);
      chk(resp, rows[i].r);
    end
    wr(8'h1C, 32'h1);
    chk(resp, UFTS_RESP_SLVERR);
    wr(UFTS_OFF_BAUD, 32'h0);
    chk(resp, UFTS_RESP_OKAY);
    for (int i = 0; i < 17; i++)
      wr(UFTS_OFF_TXFIFO, 32'hA0 + i);
    rd(UFTS_OFF_TXFIFO);
    chk(data, {UFTS_FIFO_FULL, 8'h00});
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h20);
    wr(UFTS_OFF_STATUS, 32'h70);
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h20);
    wr(UFTS_OFF_STATUS, 32'h0);
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h0);
    wr(UFTS_OFF_IRQ_ST, 32'h70);
    wr(UFTS_OFF_IRQ_MASK, 32'h20);
    chk(irq, 1'b0);
    wr(UFTS_OFF_CTRL, 32'h1);
    repeat (1000)
      if (data[6] !== 1'b1)
        rd(UFTS_OFF_STATUS);
    chk(data, 32'h60);
    chk(irq, 1'b1);
    chk(rx_byte, 8'hAF);
    wr(UFTS_OFF_IRQ_ST, 32'h70);
    chk(irq, 1'b0);
    send <= 1'b1;
    @(posedge aclk) send <= 1'b0;
    repeat (200) @(posedge aclk);
    // Break was never read while set, so this zero leaves it
    wr(UFTS_OFF_STATUS, 32'h0);
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h30);
    // A second space frame sets break again and drops the earlier read mark
    send <= 1'b1;
    @(posedge aclk) send <= 1'b0;
    repeat (200) @(posedge aclk);
    wr(UFTS_OFF_STATUS, 32'h0);
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h30);
    wr(UFTS_OFF_STATUS, 32'h0);
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h20);
    rd(UFTS_OFF_IRQ_ST);
    chk(data, 32'h10);
    wr(UFTS_OFF_TXFIFO, 32'h55);
    standby <= 1'b1;
    repeat (2) @(posedge aclk);
    standby <= 1'b0;
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h60);
    rd(UFTS_OFF_CTRL);
    chk(data, 32'h0);
    rd(UFTS_OFF_TXFIFO);
    chk(data, 32'h0);
    // Standby keeps interrupt status, mask and baud; a reset does not
    chk(irq, 1'b1);
    rd(UFTS_OFF_BAUD);
    chk(data, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(UFTS_OFF_BAUD);
    chk(data, {16'h0000, UFTS_BAUD_RST});
    rd(UFTS_OFF_STATUS);
    chk(data, 32'h60);
    chk(irq, 1'b0);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end
endmodule : ufts_top_tb
`default_nettype wire

/* File: ufts_tx_shift.sv */
// Transmit shifter: start bit, eight data bits LSB first, one stop bit
`timescale 1ns/1ns
`default_nettype none
module ufts_tx_shift (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Timing and control
  input  wire logic       tick,
  input  wire logic       clr,
  // Character in
  input  wire logic       start,
  input  wire logic [7:0] data,
  // Status and line
  output logic            busy,
  output logic            done,
  output logic            txd
);
  import ufts_pkg::*;

  ufts_tx_state_t state_q;
  logic [7:0]     tx_shift_reg_q;
  logic [3:0]     ovs_q;
  logic [2:0]     bit_q;
  logic           txd_q;
  logic           done_q;

  assign busy = (state_q != UFTS_TX_IDLE);
  assign done = done_q;
  assign txd  = txd_q;

  always_ff @(posedge aclk) begin
    done_q <= 1'b0;
    if (!aresetn || clr) begin
      state_q        <= UFTS_TX_IDLE;
      tx_shift_reg_q <= 8'h00;
      ovs_q          <= 4'h0;
      bit_q          <= 3'h0;
      txd_q          <= 1'b1;
    end else begin
      case (state_q)
        UFTS_TX_IDLE: begin
          txd_q <= 1'b1;
          if (start) begin
            tx_shift_reg_q <= data;
            ovs_q          <= 4'h0;
            txd_q          <= 1'b0;
            state_q        <= UFTS_TX_START;
          end
        end
        UFTS_TX_START, UFTS_TX_DATA, UFTS_TX_STOP: begin
          if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            if (ovs_q == UFTS_OVS_LAST) begin
              case (state_q)
                UFTS_TX_START: begin
                  txd_q          <= tx_shift_reg_q[0];
                  tx_shift_reg_q <= {1'b1, tx_shift_reg_q[7:1]};
                  bit_q          <= 3'h0;
                  state_q        <= UFTS_TX_DATA;
                end
                UFTS_TX_DATA: begin
                  txd_q          <= (bit_q == UFTS_LAST_DBIT) ? 1'b1 : tx_shift_reg_q[0];
                  tx_shift_reg_q <= {1'b1, tx_shift_reg_q[7:1]};
                  bit_q          <= bit_q + 3'h1;
                  if (bit_q == UFTS_LAST_DBIT) begin
                    state_q <= UFTS_TX_STOP;
                  end
                end
                default: begin
                  // Final bit of the character has left the line
                  done_q  <= 1'b1;
                  state_q <= UFTS_TX_IDLE;
                end
              endcase
            end
          end
        end
        default: state_q <= UFTS_TX_IDLE;
      endcase
    end
  end

endmodule : ufts_tx_shift
`default_nettype wire
